// [shared/serial_ctrl_pkg.sv]
// Purpose: Shared constants for the serial controller reset/init register bank
// Assumes: APB, 32-bit data, one word per register
// Notes:   Byte addresses are chosen locally; control bytes sit in bits 7:0
package serial_ctrl_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_MIRC      = 8'h00; // master_interrupt_reset_control
	localparam logic [7:0] OFF_CMD_A     = 8'h04; // command_reg, channel A
	localparam logic [7:0] OFF_CMD_B     = 8'h08; // command_reg, channel B
	localparam logic [7:0] OFF_ESE_A     = 8'h0C; // ext_status_enable_reg A
	localparam logic [7:0] OFF_ESE_B     = 8'h10; // ext_status_enable_reg B
	localparam logic [7:0] OFF_STAT_A    = 8'h14; // channel A status
	localparam logic [7:0] OFF_STAT_B    = 8'h18; // channel B status
	localparam logic [7:0] OFF_PTR       = 8'h1C; // register pointer readback
	localparam logic [7:0] OFF_HOST_STRB = 8'h20; // raw host strobe emulation
	// Master control fields
	localparam int MIRC_RST_HI  = 7;
	localparam int MIRC_RST_LO  = 6;
	localparam int MIRC_UNUSED  = 5;
	localparam int MIRC_MIE     = 3;
	localparam int MIRC_NOVEC   = 1;
	localparam logic [1:0] RST_NONE  = 2'h0;
	localparam logic [1:0] RST_CH_B  = 2'h1;
	localparam logic [1:0] RST_CH_A  = 2'h2;
	localparam logic [1:0] RST_FULL  = 2'h3;
	// Command codes
	localparam logic [7:0] CMD_RST_CRC = 8'h80;
	localparam logic [7:0] CMD_RST_EXT = 8'h10;
	// Reset values
	localparam logic [7:0] MIRC_RESET  = 8'h00;
	localparam logic [7:0] ESE_RESET   = 8'hF8;
	localparam logic [3:0] PTR_RESET   = 4'h0;
	// Recovery times in peripheral clock cycles
	localparam int RECOVERY_CYC       = 6;
	localparam int RESET_RECOVERY_CYC = 11;
endpackage

// [core/chan_reset_ctrl.sv]
// Purpose: Per-channel state touched by reset commands
// Assumes: Commands are one-cycle pulses from the register bank
// Notes:   Write registers of each channel are independent
`timescale 1ns/100ps
module chan_reset_ctrl
	import serial_ctrl_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       chan_reset,
	input  wire logic       ese_we,
	input  wire logic [7:0] ese_wdata,
	input  wire logic       crc_preset,
	input  wire logic       ext_latch_clr,
	input  wire logic       ext_event,
	input  wire logic       rx_en_set,
	input  wire logic       tx_en_set,
	output logic      [7:0] ese_q,
	output logic            rx_en_q,
	output logic            tx_en_q,
	output logic            ip_q,
	output logic            ius_q,
	output logic            int_en_q,
	output logic            ext_latch_q,
	output logic            crc_preset_q
);
	logic [7:0] ese_d;
	logic       rx_en_d, tx_en_d, ip_d, ius_d, int_en_d, ext_latch_d, crc_preset_d;

	// Next state; a channel reset overrides every enable and pending bit
	always_comb begin
		ese_d        = ese_we ? ese_wdata : ese_q;
		rx_en_d      = rx_en_q | rx_en_set;
		tx_en_d      = tx_en_q | tx_en_set;
		int_en_d     = int_en_q | (ese_we & |ese_wdata);
		ext_latch_d  = ext_event | (ext_latch_q & ~ext_latch_clr); // Event wins over clear
		ip_d         = ip_q | (ext_latch_d & int_en_d);
		ius_d        = ius_q;
		crc_preset_d = crc_preset;
		if (chan_reset) begin
			rx_en_d     = 1'b0;
			tx_en_d     = 1'b0;
			ip_d        = 1'b0;
			ius_d       = 1'b0;
			int_en_d    = 1'b0;
			ext_latch_d = 1'b0;
			ese_d       = ESE_RESET;
		end
	end

	// State registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ese_q        <= ESE_RESET;
			rx_en_q      <= 1'b0;
			tx_en_q      <= 1'b0;
			ip_q         <= 1'b0;
			ius_q        <= 1'b0;
			int_en_q     <= 1'b0;
			ext_latch_q  <= 1'b0;
			crc_preset_q <= 1'b0;
		end else begin
			ese_q        <= ese_d;
			rx_en_q      <= rx_en_d;
			tx_en_q      <= tx_en_d;
			ip_q         <= ip_d;
			ius_q        <= ius_d;
			int_en_q     <= int_en_d;
			ext_latch_q  <= ext_latch_d;
			crc_preset_q <= crc_preset_d;
		end
	end

	chk_reset_clears: assert property (@(posedge pclk) disable iff (!presetn)
		chan_reset |=> (!rx_en_q && !tx_en_q && !ip_q && !ius_q && !int_en_q && ese_q == ESE_RESET))
		else $error("channel reset left state set");
	chk_crc_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		crc_preset |=> crc_preset_q ##1 !crc_preset_q)
		else $error("crc preset pulse held");
endmodule // chan_reset_ctrl

// [core/serial_ctrl_reset_init_regs.sv]
// Purpose: Master interrupt/reset control, channel resets, enable readback over APB
// Assumes: Single 50 MHz pclk; host strobes emulated by a register write
// Notes:   Command bits are pulses, never stored
`timescale 1ns/100ps

module serial_ctrl_reset_init_regs
	import serial_ctrl_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	input  wire logic        ext_event_a,
	input  wire logic        ext_event_b,
	input  wire logic        intack,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             txd_a,
	output logic             txd_b,
	output logic             modem_a,
	output logic             modem_b,
	output logic             vec_drive,
	output logic             mie_out
);
	logic [7:0]  mirc_q, mirc_d;
	logic [3:0]  ptr_q, ptr_d;
	logic [31:0] prdata_d;
	logic        pready_d, pslverr_d;
	logic        wr_acc, rd_acc, rd_setup, hw_strobe_rst;
	logic        full_rst, rst_a, rst_b;
	logic        crc_a, crc_b, extclr_a, extclr_b, ese_we_a, ese_we_b;
	logic        rxs_a, rxs_b, txs_a, txs_b;
	logic        txd_a_d, txd_b_d, modem_a_d, modem_b_d, vec_d, mie_d;
	logic [7:0]  ese_a, ese_b;
	logic        rx_a, tx_a, ip_a, ius_a, ie_a, el_a, cp_a;
	logic        rx_b, tx_b, ip_b, ius_b, ie_b, el_b, cp_b;

	// APB access phase; pready is already high in the first access cycle
	assign wr_acc   = psel & penable & pwrite & pready;
	assign rd_acc   = psel & penable & ~pwrite & pready;
	assign pready_d = psel & ~penable; // Ready in the access cycle
	// Reads decode in the setup cycle so the data stands while pready is high
	assign rd_setup = psel & ~penable & ~pwrite;

	// Both strobes low emulated by writing 00 to the strobe register
	assign hw_strobe_rst = wr_acc && paddr == OFF_HOST_STRB && pstrb[0] && pwdata[1:0] == 2'h0;

	// Command decode: reset bits act as one-cycle pulses only
	always_comb begin
		full_rst = hw_strobe_rst;
		rst_a    = 1'b0;
		rst_b    = 1'b0;
		if (wr_acc && paddr == OFF_MIRC && pstrb[0]) begin
			unique case (pwdata[MIRC_RST_HI:MIRC_RST_LO])
				RST_FULL: full_rst = 1'b1;
				RST_CH_A: rst_a    = 1'b1;
				RST_CH_B: rst_b    = 1'b1;
				RST_NONE: ;
			endcase
		end
	end

	// Full reset hits both channels exactly as hardware reset does
	assign crc_a    = wr_acc && paddr == OFF_CMD_A && pstrb[0] && pwdata[7:0] == CMD_RST_CRC;
	assign crc_b    = wr_acc && paddr == OFF_CMD_B && pstrb[0] && pwdata[7:0] == CMD_RST_CRC;
	assign extclr_a = wr_acc && paddr == OFF_CMD_A && pstrb[0] && pwdata[7:0] == CMD_RST_EXT;
	assign extclr_b = wr_acc && paddr == OFF_CMD_B && pstrb[0] && pwdata[7:0] == CMD_RST_EXT;
	assign ese_we_a = wr_acc && paddr == OFF_ESE_A && pstrb[0];
	assign ese_we_b = wr_acc && paddr == OFF_ESE_B && pstrb[0];
	// Status register bits 0/1 request rx/tx enable in this reduced model
	assign rxs_a = wr_acc && paddr == OFF_STAT_A && pstrb[0] && pwdata[0];
	assign txs_a = wr_acc && paddr == OFF_STAT_A && pstrb[0] && pwdata[1];
	assign rxs_b = wr_acc && paddr == OFF_STAT_B && pstrb[0] && pwdata[0];
	assign txs_b = wr_acc && paddr == OFF_STAT_B && pstrb[0] && pwdata[1];

	// Per-channel state, independent sets
	chan_reset_ctrl u_chan_a (
		.pclk         (pclk),
		.presetn      (presetn),
		.chan_reset   (rst_a | full_rst),
		.ese_we       (ese_we_a),
		.ese_wdata    (pwdata[7:0]),
		.crc_preset   (crc_a),
		.ext_latch_clr(extclr_a),
		.ext_event    (ext_event_a),
		.rx_en_set    (rxs_a),
		.tx_en_set    (txs_a),
		.ese_q        (ese_a),
		.rx_en_q      (rx_a),
		.tx_en_q      (tx_a),
		.ip_q         (ip_a),
		.ius_q        (ius_a),
		.int_en_q     (ie_a),
		.ext_latch_q  (el_a),
		.crc_preset_q (cp_a)
	);
	chan_reset_ctrl u_chan_b (
		.pclk         (pclk),
		.presetn      (presetn),
		.chan_reset   (rst_b | full_rst),
		.ese_we       (ese_we_b),
		.ese_wdata    (pwdata[7:0]),
		.crc_preset   (crc_b),
		.ext_latch_clr(extclr_b),
		.ext_event    (ext_event_b),
		.rx_en_set    (rxs_b),
		.tx_en_set    (txs_b),
		.ese_q        (ese_b),
		.rx_en_q      (rx_b),
		.tx_en_q      (tx_b),
		.ip_q         (ip_b),
		.ius_q        (ius_b),
		.int_en_q     (ie_b),
		.ext_latch_q  (el_b),
		.crc_preset_q (cp_b)
	);

	// Shared master register: mode bits stored, command bits dropped
	always_comb begin
		mirc_d = mirc_q;
		ptr_d  = ptr_q;
		if (wr_acc && paddr == OFF_MIRC && pstrb[0]) begin
			mirc_d = {3'h0, pwdata[4:0]};
		end
		if (full_rst) begin
			mirc_d = MIRC_RESET;
		end
		if (rd_acc) begin
			ptr_d = PTR_RESET;
		end else if (wr_acc && paddr == OFF_CMD_A && pstrb[0]) begin
			ptr_d = pwdata[3:0]; // Pointer follows command low nibble
		end
		if (full_rst) begin
			ptr_d = PTR_RESET;
		end
	end

	// Read mux from the setup cycle; unmapped addresses read zero with an error
	always_comb begin
		prdata_d  = 32'h0000_0000;
		pslverr_d = 1'b0;
		if (rd_setup) begin
			unique case (paddr)
				OFF_MIRC:   prdata_d = {24'h00_0000, mirc_q};
				OFF_ESE_A:  prdata_d = {24'h00_0000, ese_a};
				OFF_ESE_B:  prdata_d = {24'h00_0000, ese_b};
				OFF_STAT_A: prdata_d = {24'h00_0000, cp_a, el_a, ie_a, ius_a, ip_a, 1'b0, tx_a, rx_a};
				OFF_STAT_B: prdata_d = {24'h00_0000, cp_b, el_b, ie_b, ius_b, ip_b, 1'b0, tx_b, rx_b};
				OFF_PTR:    prdata_d = {28'h000_0000, ptr_q};
				OFF_CMD_A, OFF_CMD_B, OFF_HOST_STRB: prdata_d = 32'h0000_0000;
				default:    pslverr_d = 1'b1;
			endcase
		end
	end

	// Line outputs: disabled transmitter marks, modem lines high
	always_comb begin
		txd_a_d   = ~tx_a | 1'b1;
		txd_b_d   = ~tx_b | 1'b1;
		modem_a_d = (rst_a | full_rst) ? 1'b1 : modem_a;
		modem_b_d = (rst_b | full_rst) ? 1'b1 : modem_b;
		vec_d     = intack & ~mirc_d[MIRC_NOVEC];
		mie_d     = mirc_d[MIRC_MIE];
	end

	// All outputs registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mirc_q    <= MIRC_RESET;
			ptr_q     <= PTR_RESET;
			prdata    <= 32'h0000_0000;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			txd_a     <= 1'b1;
			txd_b     <= 1'b1;
			modem_a   <= 1'b1;
			modem_b   <= 1'b1;
			vec_drive <= 1'b0;
			mie_out   <= 1'b0;
		end else begin
			mirc_q    <= mirc_d;
			ptr_q     <= ptr_d;
			prdata    <= prdata_d;
			pready    <= pready_d;
			pslverr   <= pslverr_d;
			txd_a     <= txd_a_d;
			txd_b     <= txd_b_d;
			modem_a   <= modem_a_d;
			modem_b   <= modem_b_d;
			vec_drive <= vec_d;
			mie_out   <= mie_d;
		end
	end

	// Bus handshake: answered in the first access cycle, read data released after
	chk_no_wait: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable |-> pready)
		else $error("access cycle without ready");
	chk_rd_release: assert property (@(posedge pclk) disable iff (!presetn)
		rd_acc |=> prdata == 32'h0000_0000)
		else $error("read data held past the access");
	chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
		rd_acc && paddr > OFF_HOST_STRB |-> pslverr)
		else $error("unmapped read not flagged");
	chk_ptr_load: assert property (@(posedge pclk) disable iff (!presetn)
		wr_acc && paddr == OFF_CMD_A |=> ptr_q == $past(pwdata[3:0]))
		else $error("pointer not loaded by command write");

	// Master register: command bits pulse, mode bits stored
	chk_cmd_not_stored: assert property (@(posedge pclk) disable iff (!presetn)
		wr_acc && paddr == OFF_MIRC |=> mirc_q[7:5] == 3'h0)
		else $error("command bits stored");
	chk_mode_hold: assert property (@(posedge pclk) disable iff (!presetn)
		wr_acc && paddr == OFF_MIRC && pwdata[7:6] != RST_FULL |=> mirc_q[4:0] == $past(pwdata[4:0]))
		else $error("mode bits not stored");
	chk_no_toggle: assert property (@(posedge pclk) disable iff (!presetn)
		wr_acc && paddr == OFF_MIRC && pwdata[7:6] == RST_NONE |=> $stable(rx_a) && $stable(tx_a))
		else $error("plain mode write changed channel state");

	// Acknowledge vector follows the no-vector mode bit
	chk_novec: assert property (@(posedge pclk) disable iff (!presetn)
		mirc_q[MIRC_NOVEC] && !wr_acc && !full_rst |=> !vec_drive)
		else $error("vector driven in no-vector mode");
	chk_vec_supply: assert property (@(posedge pclk) disable iff (!presetn)
		intack && !mirc_d[MIRC_NOVEC] |=> vec_drive)
		else $error("vector withheld in vector mode");

	// Resets: full reset reaches both channels, a channel reset only its own
	chk_full_reset: assert property (@(posedge pclk) disable iff (!presetn)
		full_rst |=> mirc_q == MIRC_RESET && !rx_a && !rx_b)
		else $error("full reset incomplete");
	chk_full_both: assert property (@(posedge pclk) disable iff (!presetn)
		full_rst |=> !tx_b && !ie_a && !ie_b && ese_a == ESE_RESET && ese_b == ESE_RESET)
		else $error("full reset missed a channel");
	chk_strobe_reset: assert property (@(posedge pclk) disable iff (!presetn)
		hw_strobe_rst |=> ptr_q == PTR_RESET ##1 !ie_a || $past(ese_we_a))
		else $error("strobe reset ignored");
	chk_chan_reset: assert property (@(posedge pclk) disable iff (!presetn)
		rst_a |=> !tx_a && modem_a && txd_a)
		else $error("channel reset outputs wrong");
	chk_chan_b_reset: assert property (@(posedge pclk) disable iff (!presetn)
		rst_b |=> !tx_b && !rx_b && modem_b && txd_b)
		else $error("channel b reset outputs wrong");
	chk_chan_apart: assert property (@(posedge pclk) disable iff (!presetn)
		rst_b |=> $stable(rx_a) && $stable(tx_a))
		else $error("channel b reset touched channel a");

	// Channel commands: check-sequence preset and external latch clear
	chk_crc_start: assert property (@(posedge pclk) disable iff (!presetn)
		crc_a |=> cp_a)
		else $error("check sequence preset missing");
	chk_ext_clear: assert property (@(posedge pclk) disable iff (!presetn)
		extclr_a && !ext_event_a |=> !el_a)
		else $error("external latch not cleared");

	// Pointer return and enable readback
	chk_ptr_zero: assert property (@(posedge pclk) disable iff (!presetn)
		rd_acc && !full_rst |=> ptr_q == PTR_RESET)
		else $error("pointer not returned");
	chk_readback: assert property (@(posedge pclk) disable iff (!presetn)
		rd_acc && paddr == OFF_ESE_A |-> prdata[7:0] == $past(ese_a) && prdata[31:8] == 24'h00_0000)
		else $error("enable readback wrong");
	chk_readback_b: assert property (@(posedge pclk) disable iff (!presetn)
		rd_acc && paddr == OFF_ESE_B |-> prdata[7:0] == $past(ese_b) && prdata[31:8] == 24'h00_0000)
		else $error("enable readback b wrong");

	// Scenarios the bench is expected to reach
	cov_full_reset: cover property (@(posedge pclk) full_rst);
	cov_chan_b_reset: cover property (@(posedge pclk) rst_b);
	cov_ext_clear: cover property (@(posedge pclk) extclr_a ##[1:40] extclr_a);
	cov_strobe_reset: cover property (@(posedge pclk) hw_strobe_rst);
	cov_novec_ack: cover property (@(posedge pclk) intack && mirc_q[MIRC_NOVEC]);
endmodule // serial_ctrl_reset_init_regs

// [tb/host_model.sv]
// Purpose: Host processor model driving the register bank over APB
// Assumes: One pclk domain; the slave raises pready by itself
// Notes:   Released write data is inverted so a stale word never looks valid
`timescale 1ns/100ps
module host_model (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata,
	output logic      [3:0]  pstrb,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// Idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hF;
	end

	// One transfer, then the spacing the device needs before the next one
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input int gap,
			output logic [31:0] rd, output logic err, output logic ok);
		int n;
		ok = 1'b0;
		rd = 32'h0000_0000;
		err = 1'b0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20 && !ok; n++) begin
			@(posedge pclk);
			ok = (pready === 1'b1);
			if (ok) begin
				rd = prdata; // Taken at the ready edge only
				err = pslverr;
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d; // Released data never repeats
		repeat (gap) @(posedge pclk);
	endtask
endmodule // host_model

// [tb/testbench.sv]
// Purpose: Self-checking bench for the reset/init register bank
// Assumes: Host model spaces accesses; seed fixed at 15
// Notes:   Strobe pulses too short for APB are checked as cleared only
`timescale 1ns/100ps
module testbench
	import serial_ctrl_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ok, err;
	logic        ext_event_a, ext_event_b, intack, txd_a, txd_b, modem_a, modem_b, vec_drive, mie_out;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, v, w;
	logic [3:0]  pstrb;
	int          error_cnt, checks_done, seed, i, ch;

	host_model host_model_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	serial_ctrl_reset_init_regs serial_ctrl_reset_init_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.ext_event_a(ext_event_a), .ext_event_b(ext_event_b), .intack(intack), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .txd_a(txd_a), .txd_b(txd_b), .modem_a(modem_a),
		.modem_b(modem_b), .vec_drive(vec_drive), .mie_out(mie_out));

	// 50 MHz clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// Stored mode bits read back without the command bits
	function automatic logic [31:0] mode_exp(input logic [31:0] m);
		return {27'h0, m[4:0]};
	endfunction

	task automatic give_verdict();
		$display("checks_done %0d error_cnt %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// A hung transfer ends the run at once
	task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d, input int gap);
		host_model_i.xfer(wr, a, d, gap, rd, err, ok);
		if (!ok) begin
			error_cnt++;
			give_verdict();
		end
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
		acc(1'b0, a, 32'h0, 6);
		check(what, rd & msk, exp);
	endtask

	task automatic chk_reset_state();
		rd_chk("mode", OFF_MIRC, {24'h0, MIRC_RESET}, 32'hFFFF_FFFF);
		rd_chk("ese_a", OFF_ESE_A, {24'h0, ESE_RESET}, 32'hFFFF_FFFF);
		rd_chk("ese_b", OFF_ESE_B, {24'h0, ESE_RESET}, 32'hFFFF_FFFF);
		rd_chk("stat_a", OFF_STAT_A, 32'h0, 32'hFFFF_FFFF);
		rd_chk("stat_b", OFF_STAT_B, 32'h0, 32'hFFFF_FFFF);
		check("lines", {28'h0, txd_a, txd_b, modem_a, modem_b}, 32'hF);
	endtask

	// Main sequence
	initial begin
		error_cnt = 0;
		checks_done = 0;
		seed = 15;
		presetn = 1'b0;
		{ext_event_a, ext_event_b, intack} = 3'b000;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (11) @(posedge pclk);
		rd_chk("pointer", OFF_PTR, {28'h0, PTR_RESET}, 32'hFFFF_FFFF);
		chk_reset_state();
		// Mode bits with corners, intack random; D5 always written zero
		for (i = 0; i < 10; i++) begin
			v = (i == 0) ? 32'h1F : (i == 1) ? 32'h0 : $random(seed) & 32'h1F;
			intack <= v[2];
			acc(1'b1, OFF_MIRC, v, 6);
			rd_chk("mode", OFF_MIRC, mode_exp(v), 32'hFFFF_FFFF);
			check("mie", {31'h0, mie_out}, {31'h0, v[MIRC_MIE]});
			check("vector", {31'h0, vec_drive}, {31'h0, v[2] & ~v[MIRC_NOVEC]});
		end
		// Enable registers per channel stay apart
		for (i = 0; i < 6; i++) begin
			v = (i == 0) ? 32'h0 : $random(seed) & 32'hFF;
			w = (i == 0) ? 32'hFF : $random(seed) & 32'hFF;
			acc(1'b1, OFF_ESE_A, v, 6);
			acc(1'b1, OFF_ESE_B, w, 6);
			rd_chk("ese_a", OFF_ESE_A, v, 32'hFFFF_FFFF);
			rd_chk("ese_b", OFF_ESE_B, w, 32'hFFFF_FFFF);
		end
		// Channel resets, mode bits repeated with each command
		for (ch = 0; ch < 2; ch++) begin
			acc(1'b1, OFF_STAT_A, 32'h3, 6);
			acc(1'b1, OFF_STAT_B, 32'h3, 6);
			v = $random(seed) & 32'h1F;
			acc(1'b1, OFF_MIRC, v | ((ch == 0) ? 32'h80 : 32'h40), 6);
			rd_chk("mode", OFF_MIRC, mode_exp(v), 32'hFFFF_FFFF);
			rd_chk("stat_rst", (ch == 0) ? OFF_STAT_A : OFF_STAT_B, 32'h0, 32'h3F);
			// Channel B still has interrupts on from the all-ones enable write
			rd_chk("stat_other", (ch == 0) ? OFF_STAT_B : OFF_STAT_A, (ch == 0) ? 32'h23 : 32'h03, 32'h3F);
			check("lines", {28'h0, txd_a, txd_b, modem_a, modem_b}, 32'hF);
			acc(1'b1, (ch == 0) ? OFF_STAT_A : OFF_STAT_B, 32'h3, 6);
			acc(1'b1, OFF_MIRC, v, 6);
			rd_chk("no_retrig", (ch == 0) ? OFF_STAT_A : OFF_STAT_B, 32'h3, 32'h3F);
		end
		// Full reset by command, then by both strobes low
		for (i = 0; i < 2; i++) begin
			acc(1'b1, OFF_MIRC, 32'h0B, 6);
			acc(1'b1, OFF_ESE_A, $random(seed) & 32'h7, 6);
			acc(1'b1, OFF_STAT_B, 32'h3, 6);
			acc(1'b1, (i == 0) ? OFF_MIRC : OFF_HOST_STRB, (i == 0) ? 32'hC0 : 32'h0, 11);
			chk_reset_state();
		end
		// Ordered init: modes, enables, interrupts
		acc(1'b1, OFF_MIRC, 32'h03, 6);
		acc(1'b1, OFF_STAT_A, 32'h3, 6);
		acc(1'b1, OFF_CMD_A, {24'h0, CMD_RST_CRC}, 6);
		rd_chk("crc", OFF_STAT_A, 32'h0, 32'h80);
		ext_event_a <= 1'b1;
		@(posedge pclk);
		ext_event_a <= 1'b0;
		rd_chk("latch_set", OFF_STAT_A, 32'h40, 32'h40);
		acc(1'b1, OFF_ESE_A, {24'h0, ESE_RESET}, 6);
		acc(1'b1, OFF_CMD_A, {24'h0, CMD_RST_EXT}, 6);
		acc(1'b1, OFF_CMD_A, {24'h0, CMD_RST_EXT}, 6);
		rd_chk("latch_clr", OFF_STAT_A, 32'h0, 32'h40);
		acc(1'b1, OFF_MIRC, 32'h0B, 6);
		check("mie", {31'h0, mie_out}, 32'h1);
		// Pointer loaded by a command write, cleared by a read
		acc(1'b1, OFF_CMD_A, 32'h5, 6);
		rd_chk("ptr_load", OFF_PTR, 32'h5, 32'hFFFF_FFFF);
		acc(1'b1, OFF_CMD_A, 32'h5, 6);
		acc(1'b0, OFF_STAT_A, 32'h0, 6);
		rd_chk("pointer", OFF_PTR, 32'h0, 32'hFFFF_FFFF);
		acc(1'b0, 8'hF0, 32'h0, 6);
		check("slverr", {31'h0, err}, 32'h1);
		give_verdict();
	end
endmodule // testbench
